// *** bt_pkg.sv ***
// Constants shared by the stream pattern tester and its sample FIFO
package bt_pkg;

	// ------------------------------------------------------------
	// Register map (word addresses on the 14-bit processor port)
	// ------------------------------------------------------------
	localparam logic [13:0] IMS_ADDR = 14'h0010;
	localparam logic [13:0] SRR_ADDR = 14'h0011;
	localparam logic [13:0] RX_CTRL_BASE = 14'h0100;
	localparam logic [13:0] RX_START_BASE = 14'h0120;
	localparam logic [13:0] RX_LEN_BASE = 14'h0140;
	localparam logic [13:0] RX_ERR_BASE = 14'h0160;

	// ------------------------------------------------------------
	// Field positions, widths and stream count
	// ------------------------------------------------------------
	localparam int RXEN_BIT = 5;
	localparam int TXEN_BIT = 4;
	localparam int SWRST_BIT = 1;
	localparam int CLR_BIT = 1;
	localparam int SEN_BIT = 0;
	localparam int START_W = 8;
	localparam int LEN_W = 9;
	localparam int CNT_W = 16;
	localparam int STREAMS = 32;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [14:0] LFSR_SEED = 15'h7FFF;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [1:0] PCC_BER = 2'h2;
	localparam logic [8:0] LEN_RESET = 9'h000;
	localparam logic [7:0] START_RESET = 8'h00;

	// ------------------------------------------------------------
	// Sample FIFO shape
	// ------------------------------------------------------------
	localparam int FIFO_WIDTH = 43;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_MARGIN = 3;

endpackage

// *** bt_fifo.sv ***
// Synchronous FIFO carrying received bit slots to the comparators
`timescale 1ns/1ps
module bt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int MARGIN = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic flush,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	// Status
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
	localparam logic [AW:0] LIMIT_C = (AW + 1)'(DEPTH - MARGIN);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0] count;
		logic ready;
	} bt_fifo_state_t;

	bt_fifo_state_t q;
	bt_fifo_state_t d;
	logic push;
	logic pop;

	assign full = (q.count == DEPTH_C);
	assign empty = (q.count == '0);
	assign outValid = !empty;
	assign outData = q.mem[q.rdPtr];
	assign inReady = q.ready;

	always_comb
	begin
		d = q;
		push = inValid && !full;
		pop = outReady && !empty;
		if (push)
		begin
			d.mem[q.wrPtr] = inData;
			d.wrPtr = q.wrPtr + 1'b1;
		end
		if (pop)
			d.rdPtr = q.rdPtr + 1'b1;
		d.count = q.count + (AW + 1)'(push) - (AW + 1)'(pop);
		if (flush)
		begin
			d.wrPtr = '0;
			d.rdPtr = '0;
			d.count = '0;
		end
		// Margin covers samples already in the input pipeline
		d.ready = (d.count < LIMIT_C);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.ready <= 1'b1;
		end
		else
			q <= d;
	end

	a_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (rst)
		full |-> !inReady)
		else $error("fifo reports ready while full");

endmodule // bt_fifo

// *** bt_tester.sv ***
// Per-stream pseudo-random pattern transmitters and error-counting receivers
`timescale 1ns/1ps
module bt_tester (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Processor register port
	input wire logic cpuSel,
	input wire logic cpuWr,
	input wire logic [13:0] cpuAddr,
	input wire logic [15:0] cpuWrData,
	output logic [15:0] cpuRdData,
	output logic cpuAck,
	// Switch frame timing, one strobe per bit slot
	input wire logic slotStrobe,
	input wire logic [7:0] slotChan,
	input wire logic [2:0] slotBit,
	output logic slotReady,
	// Connection entry low of the current output channel, per stream
	input wire logic [31:0] connection_mode_bit,
	input wire logic [31:0][1:0] per_channel_control_field,
	// Serial streams
	input wire logic [31:0] rxPins,
	input wire logic [31:0] txCoreBits,
	output logic [31:0] txBits
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic rxAllEn;
		logic txAllEn;
		logic softRst;
		logic [31:0] rxStreamEn;
		logic [31:0][7:0] startCh;
		logic [31:0][8:0] testLen;
		logic [31:0][15:0] errCnt;
		logic [31:0][14:0] txLfsr;
		logic [31:0][14:0] rxLfsr;
		logic [31:0] txBits;
		logic [31:0] rxMeta;
		logic [31:0] rxSync;
		logic [2:0] slotV;
		logic [2:0][7:0] slotCh;
		logic [2:0][2:0] slotBitIdx;
		logic [15:0] rdData;
		logic ack;
	} bt_state_t;

	bt_state_t q;
	bt_state_t d;

	logic wrHit;
	logic rdHit;
	logic clrHit;
	logic drainReady;
	logic [8:0] grp;
	logic [4:0] idx;
	logic fInReady;
	logic fOutValid;
	logic [42:0] fOutData;
	logic [7:0] fChan;
	logic [2:0] fBit;
	logic [31:0] fBits;

	function automatic logic [14:0] lfsrStep(input logic [14:0] v);
		return {v[13:0], v[14] ^ v[13]};
	endfunction

	assign fChan = fOutData[42:35];
	assign fBit = fOutData[34:32];
	assign fBits = fOutData[31:0];

	// ------------------------------------------------------------
	// Sample FIFO
	// ------------------------------------------------------------
	bt_fifo #(
		.WIDTH(bt_pkg::FIFO_WIDTH),
		.DEPTH(bt_pkg::FIFO_DEPTH),
		.MARGIN(bt_pkg::FIFO_MARGIN)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.flush(q.softRst),
		.inValid(q.slotV[2]),
		.inReady(fInReady),
		.inData({q.slotCh[2], q.slotBitIdx[2], q.rxSync}),
		.outValid(fOutValid),
		.outReady(drainReady),
		.outData(fOutData),
		.full(),
		.empty()
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [14:0] cur;
		logic [8:0] diff;
		logic inWin;
		logic active;
		cur = '0;
		diff = '0;
		inWin = 1'b0;
		active = 1'b0;
		d = q;
		grp = cpuAddr[13:5];
		idx = cpuAddr[4:0];
		wrHit = cpuSel && cpuWr;
		rdHit = cpuSel && !cpuWr;
		clrHit = wrHit && (grp == bt_pkg::RX_CTRL_BASE[13:5]) &&
			cpuWrData[bt_pkg::CLR_BIT];
		// A clear owns the counters for its cycle, so the drain waits
		drainReady = !clrHit;
		d.ack = cpuSel;
		d.rdData = 16'h0000;

		// Pin inputs through two flops; the pin is taken one cycle
		// after its strobe, so timing runs three deep to meet it
		d.rxMeta = rxPins;
		d.rxSync = q.rxMeta;
		d.slotV = {q.slotV[1:0], slotStrobe};
		d.slotCh = {q.slotCh[1:0], slotChan};
		d.slotBitIdx = {q.slotBitIdx[1:0], slotBit};

		// Register reads; unmapped addresses read zero
		if (rdHit)
		begin
			if (cpuAddr == bt_pkg::IMS_ADDR)
			begin
				d.rdData[bt_pkg::RXEN_BIT] = q.rxAllEn;
				d.rdData[bt_pkg::TXEN_BIT] = q.txAllEn;
			end
			else if (cpuAddr == bt_pkg::SRR_ADDR)
				d.rdData[bt_pkg::SWRST_BIT] = q.softRst;
			else if (grp == bt_pkg::RX_CTRL_BASE[13:5])
				d.rdData[bt_pkg::SEN_BIT] = q.rxStreamEn[idx];
			else if (grp == bt_pkg::RX_START_BASE[13:5])
				d.rdData = {8'h00, q.startCh[idx]};
			else if (grp == bt_pkg::RX_LEN_BASE[13:5])
				d.rdData = {7'h00, q.testLen[idx]};
			else if (grp == bt_pkg::RX_ERR_BASE[13:5])
				d.rdData = q.errCnt[idx];
		end

		// Register writes; error count register is read-only
		if (wrHit)
		begin
			if (cpuAddr == bt_pkg::IMS_ADDR)
			begin
				d.rxAllEn = cpuWrData[bt_pkg::RXEN_BIT];
				d.txAllEn = cpuWrData[bt_pkg::TXEN_BIT];
			end
			else if (cpuAddr == bt_pkg::SRR_ADDR)
				d.softRst = cpuWrData[bt_pkg::SWRST_BIT];
			else if (grp == bt_pkg::RX_CTRL_BASE[13:5])
			begin
				d.rxStreamEn[idx] = cpuWrData[bt_pkg::SEN_BIT];
				if (cpuWrData[bt_pkg::CLR_BIT])
					d.errCnt[idx] = 16'h0000;
			end
			else if (grp == bt_pkg::RX_START_BASE[13:5])
				d.startCh[idx] = cpuWrData[7:0];
			else if (grp == bt_pkg::RX_LEN_BASE[13:5])
				d.testLen[idx] = cpuWrData[8:0];
		end

		// Transmitters, one per output stream
		if (slotStrobe)
		begin
			for (int i = 0; i < bt_pkg::STREAMS; i++)
			begin
				active = q.txAllEn && connection_mode_bit[i] &&
					(per_channel_control_field[i] == bt_pkg::PCC_BER);
				// Every frame restarts the sequence from the seed
				cur = (slotChan == 8'h00 && slotBit == 3'h0) ?
					bt_pkg::LFSR_SEED : q.txLfsr[i];
				if (active)
				begin
					d.txBits[i] = cur[14];
					d.txLfsr[i] = lfsrStep(cur);
				end
				else
				begin
					d.txBits[i] = txCoreBits[i];
					d.txLfsr[i] = cur;
				end
			end
		end

		// Receivers compare the window against the local sequence
		if (fOutValid && drainReady)
		begin
			for (int i = 0; i < bt_pkg::STREAMS; i++)
			begin
				diff = {1'b0, fChan} - {1'b0, q.startCh[i]};
				inWin = (fChan >= q.startCh[i]) &&
					(diff < q.testLen[i]);
				cur = (fChan == q.startCh[i] && fBit == 3'h0) ?
					bt_pkg::LFSR_SEED : q.rxLfsr[i];
				if (q.rxAllEn && q.rxStreamEn[i] && inWin)
				begin
					d.rxLfsr[i] = lfsrStep(cur);
					if ((fBits[i] != cur[14]) &&
						(q.errCnt[i] != bt_pkg::CNT_MAX))
						d.errCnt[i] = q.errCnt[i] + 16'h0001;
				end
			end
		end

		// Switch software reset holds the test logic cleared
		if (q.softRst)
		begin
			d.rxAllEn = 1'b0;
			d.txAllEn = 1'b0;
			d.rxStreamEn = '0;
			d.startCh = {32{bt_pkg::START_RESET}};
			d.testLen = {32{bt_pkg::LEN_RESET}};
			d.errCnt = '0;
			d.txLfsr = {32{bt_pkg::LFSR_SEED}};
			d.rxLfsr = {32{bt_pkg::LFSR_SEED}};
			d.txBits = '0;
			d.slotV = '0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.startCh <= {32{bt_pkg::START_RESET}};
			q.testLen <= {32{bt_pkg::LEN_RESET}};
			q.txLfsr <= {32{bt_pkg::LFSR_SEED}};
			q.rxLfsr <= {32{bt_pkg::LFSR_SEED}};
		end
		else
			q <= d;
	end

	assign cpuRdData = q.rdData;
	assign cpuAck = q.ack;
	assign txBits = q.txBits;
	assign slotReady = fInReady;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_clear_write;
		cpuSel && cpuWr && (grp == bt_pkg::RX_CTRL_BASE[13:5]) &&
			(idx == 5'h03) && cpuWrData[bt_pkg::CLR_BIT];
	endsequence

	sequence s_tx_frame_start;
		slotStrobe && slotChan == 8'h00 && slotBit == 3'h0 &&
			q.txAllEn && connection_mode_bit[0] &&
			per_channel_control_field[0] == bt_pkg::PCC_BER && !q.softRst;
	endsequence

	a_enables_after_reset: assert property (
		$past(rst) |-> !q.rxAllEn && !q.txAllEn && q.errCnt[3] == 16'h0000)
		else $error("enables or counter not cleared by reset");

	a_tx_gate_mode: assert property (
		slotStrobe && !q.softRst &&
			!(connection_mode_bit[0] &&
			per_channel_control_field[0] == bt_pkg::PCC_BER)
		|=> txBits[0] == $past(txCoreBits[0]))
		else $error("pattern on channel without test entry");

	a_tx_seed_start: assert property (
		s_tx_frame_start |=> txBits[0] == 1'b1 &&
			q.txLfsr[0] == {bt_pkg::LFSR_SEED[13:0], 1'b0})
		else $error("transmitter did not restart from seed");

	a_lfsr_never_zero: assert property (
		q.txLfsr[0] != 15'h0000 && q.rxLfsr[0] != 15'h0000)
		else $error("sequence generator locked at zero");

	a_err_clear_write: assert property (
		s_clear_write |=> q.errCnt[3] == 16'h0000 ##1
			q.errCnt[3] <= 16'h0001)
		else $error("error count not cleared by control write");

	a_err_saturate_hold: assert property (
		q.errCnt[3] == bt_pkg::CNT_MAX && !clrHit && !q.softRst
		|=> q.errCnt[3] == bt_pkg::CNT_MAX)
		else $error("error count wrapped past maximum");

	a_err_single_step: assert property (
		// A clear shows one cycle after its write, hence the past terms
		!$past(clrHit) && !$past(q.softRst) &&
			q.errCnt[3] != $past(q.errCnt[3])
		|-> q.errCnt[3] == $past(q.errCnt[3]) + 16'h0001)
		else $error("error count moved by other than one");

	a_err_idle_hold: assert property (
		!q.rxAllEn && !clrHit |=> $stable(q.errCnt[3]))
		else $error("error count moved with receivers disabled");

	a_soft_reset_clear: assert property (
		q.softRst |=> !q.txAllEn && !q.rxAllEn &&
			q.errCnt[3] == 16'h0000 && txBits == 32'h0000_0000)
		else $error("software reset left test logic running");

endmodule // bt_tester

// *** bt_loop_model.sv ***
// Loopback model of the far-side stream equipment
`timescale 1ns/1ps
module bt_loop_model (
	// Transmitted streams
	input wire logic [31:0] txBits,
	// Error injection, one bit per stream
	input wire logic [31:0] flipMask,
	// Echoed streams
	output logic [31:0] rxPins
);
	// ------------------------------------------------------------
	// Echo
	// ------------------------------------------------------------
	// Slots return in order, so the receive window sees the very
	// run of channels the pattern left on; no retiming is added
	assign rxPins = txBits ^ flipMask;
endmodule // bt_loop_model

// *** tb_top.sv ***
// Self-checking bench for the stream pattern tester
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, cpuSel = 1'b0, cpuWr = 1'b0;
	logic [13:0] cpuAddr = 14'h0000;
	logic [15:0] cpuWrData = 16'h0000, cpuRdData, rd;
	logic cpuAck, slotReady, slotStrobe = 1'b0;
	logic [7:0] slotChan = 8'h00;
	logic [2:0] slotBit = 3'h0;
	logic [31:0] modeBits = 32'h0, txCore = 32'h0, flipMask = 32'h0;
	logic [31:0][1:0] pccBits = {32{2'h2}};
	logic [31:0] rxPins, txBits, expTx;
	logic [14:0] lfsr = bt_pkg::LFSR_SEED;
	logic [1:0] pcc = 2'h2;
	logic genOn = 0, checkTx = 0, txEnM = 0, flipOn = 0, sawStall = 0;
	logic pat, inWin;
	int gap = 3, idle = 0, frameCnt = 0, cycles = 0, nc = 0, nb = 0;
	int patStart = 0, patLen = 32, fails = 0, num_checks = 0;

	bt_tester dut (.sys_clk(sys_clk), .rst(rst), .cpuSel(cpuSel),
		.cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
		.cpuRdData(cpuRdData), .cpuAck(cpuAck), .slotStrobe(slotStrobe),
		.slotChan(slotChan), .slotBit(slotBit), .slotReady(slotReady),
		.connection_mode_bit(modeBits), .per_channel_control_field(pccBits),
		.rxPins(rxPins), .txCoreBits(txCore), .txBits(txBits));
	bt_loop_model peer (.txBits(txBits), .flipMask(flipMask),
		.rxPins(rxPins));

	initial
	begin
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fails++;
			tally_and_finish;
		end
	end

	// ------------------------------------------------------------
	// Slot timing and transmit model
	// ------------------------------------------------------------
	initial
	begin
		forever
		begin
			@(posedge sys_clk);
			#1;
			if (slotStrobe)
			begin
				// Flip changes with txBits, so it holds over the sample edge
				flipMask = (flipOn && slotChan == 8'h07) ? 32'h8 : 32'h0;
				if (slotChan == 8'h00 && slotBit == 3'h0)
				begin
					lfsr = bt_pkg::LFSR_SEED;
					frameCnt++;
				end
				pat = txEnM && modeBits[0] && pccBits[0] == 2'h2;
				expTx = pat ? {32{lfsr[14]}} : txCore;
				if (pat)
					lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
				if (checkTx)
					check("txBits", txBits, expTx);
				nb = (nb + 1) % 8;
				if (nb == 0)
					nc = (nc + 1) % 32;
			end
			if (genOn && slotReady !== 1'b1)
				sawStall = 1;
			if (genOn && slotReady === 1'b1 && idle >= gap)
			begin
				inWin = nc >= patStart && nc < patStart + patLen;
				slotChan = nc[7:0];
				slotBit = nb[2:0];
				modeBits = {32{inWin}};
				pccBits = {32{pcc}};
				txCore = {4{nc[7:0]}} ^ {32{nb[0]}};
				slotStrobe = 1'b1;
				idle = 0;
			end
			else
			begin
				slotStrobe = 1'b0;
				idle++;
			end
		end
	end

	// ------------------------------------------------------------
	// Register port and helpers
	// ------------------------------------------------------------
	task automatic regAccess(logic wr, logic [13:0] a, logic [15:0] d);
		@(posedge sys_clk);
		#1;
		cpuSel = 1'b1;
		cpuWr = wr;
		cpuAddr = a;
		cpuWrData = d;
		@(posedge sys_clk);
		#1;
		cpuSel = 1'b0;
		rd = cpuRdData;
		check("cpuAck", cpuAck, 1'b1);
	endtask

	task automatic readCheck(string name, logic [13:0] a, logic [15:0] e);
		regAccess(1'b0, a, 16'h0000);
		check(name, rd, e);
	endtask

	task automatic waitFrames(int n);
		int f;
		f = frameCnt;
		while (frameCnt < f + n)
			@(posedge sys_clk);
	endtask

	task automatic flipFrame(logic [15:0] e);
		waitFrames(1);
		flipOn = 1;
		waitFrames(1);
		flipOn = 0;
		readCheck("rxErrCount", bt_pkg::RX_ERR_BASE + 14'h0003, e);
	endtask

	task automatic setupRx;
		patStart = 5;
		patLen = 3;
		waitFrames(2);
		regAccess(1'b1, bt_pkg::RX_START_BASE + 14'h0003, 16'h0005);
		regAccess(1'b1, bt_pkg::RX_LEN_BASE + 14'h0003, 16'h0003);
		regAccess(1'b1, bt_pkg::IMS_ADDR, 16'h0030);
		regAccess(1'b1, bt_pkg::RX_CTRL_BASE + 14'h0003, 16'h0003);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		readCheck("ims", bt_pkg::IMS_ADDR, 16'h0000);
		readCheck("rxLen", bt_pkg::RX_LEN_BASE + 14'h0003, 16'h0000);
		readCheck("rxErr", bt_pkg::RX_ERR_BASE + 14'h001F, 16'h0000);
		readCheck("unmapped", 14'h3FFF, 16'h0000);
		regAccess(1'b1, bt_pkg::RX_START_BASE + 14'h0009, 16'hFFFF);
		readCheck("rxStart", bt_pkg::RX_START_BASE + 14'h0009, 16'h00FF);
		regAccess(1'b1, bt_pkg::RX_LEN_BASE + 14'h0009, 16'hFFFF);
		readCheck("rxLen", bt_pkg::RX_LEN_BASE + 14'h0009, 16'h01FF);
		regAccess(1'b1, bt_pkg::RX_ERR_BASE + 14'h0009, 16'h1234);
		readCheck("rxErrRo", bt_pkg::RX_ERR_BASE + 14'h0009, 16'h0000);
	endtask

	task automatic t_tx;
		genOn = 1;
		regAccess(1'b1, bt_pkg::IMS_ADDR, 16'h0010);
		txEnM = 1;
		waitFrames(1);
		checkTx = 1;
		waitFrames(1);
		pcc = 2'h1;
		waitFrames(1);
		pcc = 2'h2;
		patStart = 9;
		patLen = 1;
		waitFrames(2);
		checkTx = 0;
	endtask

	task automatic t_rx;
		setupRx;
		waitFrames(1);
		readCheck("rxErrClean", bt_pkg::RX_ERR_BASE + 14'h0003, 16'h0000);
		flipFrame(16'h0008);
		regAccess(1'b1, bt_pkg::IMS_ADDR, 16'h0010);
		flipFrame(16'h0008);
		regAccess(1'b1, bt_pkg::IMS_ADDR, 16'h0030);
		regAccess(1'b1, bt_pkg::RX_CTRL_BASE + 14'h0003, 16'h0000);
		flipFrame(16'h0008);
		regAccess(1'b1, bt_pkg::RX_CTRL_BASE + 14'h0003, 16'h0002);
		readCheck("rxErrCleared", bt_pkg::RX_ERR_BASE + 14'h0003, 16'h0000);
		regAccess(1'b1, bt_pkg::RX_CTRL_BASE + 14'h0003, 16'h0003);
		readCheck("rxCtrl", bt_pkg::RX_CTRL_BASE + 14'h0003, 16'h0001);
		flipFrame(16'h0008);
	endtask

	task automatic t_soft;
		regAccess(1'b1, bt_pkg::SRR_ADDR, 16'h0002);
		repeat (3) @(posedge sys_clk);
		#1;
		check("txBitsSoft", txBits, 32'h0);
		readCheck("rxErrSoft", bt_pkg::RX_ERR_BASE + 14'h0003, 16'h0000);
		readCheck("rxLenSoft", bt_pkg::RX_LEN_BASE + 14'h0003, 16'h0000);
		readCheck("imsSoft", bt_pkg::IMS_ADDR, 16'h0000);
		regAccess(1'b1, bt_pkg::SRR_ADDR, 16'h0000);
	endtask

	task automatic t_fifo;
		// Clear writes stall the drain while slots arrive every cycle
		gap = 0;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge sys_clk);
			#1;
			cpuSel = 1'b1;
			cpuWr = 1'b1;
			cpuAddr = bt_pkg::RX_CTRL_BASE;
			cpuWrData = 16'h0002;
		end
		@(posedge sys_clk);
		#1;
		cpuSel = 1'b0;
		check("fifoRefused", sawStall, 1'b1);
		gap = 3;
		repeat (40) @(posedge sys_clk);
		#1;
		check("fifoDrained", slotReady, 1'b1);
	endtask

	task automatic t_hard;
		setupRx;
		flipFrame(16'h0008);
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		readCheck("rxErrHard", bt_pkg::RX_ERR_BASE + 14'h0003, 16'h0000);
		readCheck("rxStartHard", bt_pkg::RX_START_BASE + 14'h0003, 16'h0000);
	endtask

	initial
	begin
		repeat (4) @(posedge sys_clk);
		#1;
		check("txBitsReset", txBits, 32'h0);
		check("slotReadyReset", slotReady, 1'b1);
		rst = 1'b0;
		t_regs;
		t_tx;
		t_rx;
		t_soft;
		t_fifo;
		t_hard;
		tally_and_finish;
	end
endmodule // tb_top
